// ==== rtl/bus_area_decode.sv ====
// How it works
// - area chosen by address bits 28..26
// - bits 31..29 mirror areas every 0x20000000
// - card space areas 5,6; upper half I/O
// - boot pins set area 0 width
// - areas 2-6 width from register
// - card io sizing only little endian
// - registers 16 bits, reset only power-on
// - bit 11 read-only endian strap
// - bit 15 pulls address 4 cycles
// - bit 14 pulls data when idle
// - bit 13 low floats outputs in standby
// - bit 13 high drives outputs high
// - one select per area 0,2-6, card enables
`include "bus_area_params.svh"

module bus_area_decode (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  manual_reset_n,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire bus_area_pkg::access_s acc,
    input  wire logic                  card_io_16bit_ind,
    input  wire logic                  boot_width_pin_lo,
    input  wire logic                  boot_width_pin_hi,
    input  wire logic                  boot_endian_pin,
    input  wire logic                  standby,
    input  wire logic                  bus_release_ack,
    output bus_area_pkg::decode_s      dec,
    output logic                       little_endian,
    output logic                       addr_pullup,
    output logic                       data_pullup,
    output logic                       mem_out_force_high,
    output logic                       mem_out_float,
    output logic                       strobe_out_drive
);
    import bus_area_pkg::*;

    state_s s_q;
    state_s s_d;

    function automatic logic [1:0] bcs_width(input logic [15:0] r,
                                             input logic [2:0] a);
        logic [3:0] pos;
        pos = {a, 1'b0};
        return {r[pos + 4'h1], r[pos]};
    endfunction

    logic       wr_fire;
    logic       rd_fire;
    logic       hit_bcf;
    logic       hit_bcs;
    logic [2:0] area;
    logic [15:0] wmasked;

    assign hit_bcf = paddr == `BCF_ADDR;
    assign hit_bcs = paddr == `BCS_ADDR;
    assign wr_fire = psel && penable && pwrite;
    assign rd_fire = psel && penable && !pwrite;
    assign area    = acc.addr[`AREA_MSB:`AREA_LSB];

    always_comb begin
        s_d = s_q;
        wmasked = pwdata[15:0];
        // double-flop the pins before anything reads them
        s_d.width_pin_s1 = {boot_width_pin_hi, boot_width_pin_lo};
        s_d.width_pin_s2 = s_q.width_pin_s1;
        s_d.endian_s1    = boot_endian_pin;
        s_d.endian_s2    = s_q.endian_s1;
        s_d.back_s1      = bus_release_ack;
        s_d.back_s2      = s_q.back_s1;
        // straps caught once, after power-on release only
        // wait until the synchroniser holds the pin, not its reset value
        if (!s_q.boot_done) begin
            if (s_q.boot_cnt != 2'h2) begin
                s_d.boot_cnt = s_q.boot_cnt + 2'h1;
            end else begin
                s_d.boot_done   = 1'b1;
                s_d.area0_width = s_q.width_pin_s2;
                s_d.bcf[`BCF_ENDIAN] = s_q.endian_s2;
            end
        end
        if (wr_fire && s_q.boot_done) begin
            if (hit_bcf) begin
                if (!pstrb[0])
                    wmasked[7:0] = s_q.bcf[7:0];
                if (!pstrb[1])
                    wmasked[15:8] = s_q.bcf[15:8];
                s_d.bcf = (wmasked & `BCF_WMASK)
                        | (s_q.bcf & ~`BCF_WMASK);
            end else if (hit_bcs) begin
                wmasked = pwdata[15:0];
                if (!pstrb[0])
                    wmasked[7:0] = s_q.bcs[7:0];
                if (!pstrb[1])
                    wmasked[15:8] = s_q.bcs[15:8];
                s_d.bcs = wmasked & `BCS_WMASK;
            end
        end
        // latched in setup so it stands at the access edge
        if (psel && !penable && !pwrite)
            s_d.prdata = hit_bcf ? {16'h0000, s_q.bcf} :
                         hit_bcs ? {16'h0000, s_q.bcs} : 32'h0000_0000;
        // address pull-up for a fixed window after release ack
        case (s_q.pu_state)
            PU_IDLE: begin
                if (s_q.back_s2 && s_q.bcf[`BCF_ADDR_PU]) begin
                    s_d.pu_state = PU_HOLD;
                    s_d.pu_cnt   = `PULLUP_CYCLES;
                end
            end
            PU_HOLD: begin
                if (s_q.pu_cnt == 3'h1)
                    s_d.pu_state = PU_DONE;
                s_d.pu_cnt = s_q.pu_cnt - 3'h1;
            end
            PU_DONE: begin
                if (!s_q.back_s2)
                    s_d.pu_state = PU_IDLE;
            end
            default: s_d.pu_state = PU_IDLE;
        endcase
        // registered decode of the current access
        s_d.dec.sel_n        = 7'h7F;
        s_d.dec.card_upper_n = 2'b11;
        s_d.dec.card_io      = 1'b0;
        s_d.dec.card_dynsize = 1'b0;
        s_d.dec.internal     = 1'b0;
        s_d.dec.reserved     = 1'b0;
        s_d.dec.width        = `WID_LONG;
        if (acc.valid) begin
            case (area)
                3'd0:    s_d.dec.width = s_q.area0_width;
                3'd1:    s_d.dec.internal = 1'b1;
                3'd7:    s_d.dec.reserved = 1'b1;
                default: s_d.dec.width = bcs_width(s_q.bcs, area);
            endcase
            if (area != 3'd1 && area != 3'd7)
                s_d.dec.sel_n[area] = 1'b0;
            if ((area == 3'd5 && s_q.bcf[`BCF_A5_CARD]) ||
                (area == 3'd6 && s_q.bcf[`BCF_A6_CARD])) begin
                s_d.dec.card_io = acc.addr[`CARD_IO_BIT];
                // upper byte enable drives the second card enable
                if (acc.byte_en[1])
                    s_d.dec.card_upper_n[area == 3'd6] = 1'b0;
                s_d.dec.card_dynsize = acc.addr[`CARD_IO_BIT]
                    && s_q.bcf[`BCF_ENDIAN]
                    && card_io_16bit_ind;
            end
        end
        // manual reset: synchronisers keep running, registers kept
        if (!manual_reset_n) begin
            s_d.pu_state         = PU_IDLE;
            s_d.pu_cnt           = 3'h0;
            s_d.dec.sel_n        = 7'h7F;
            s_d.dec.card_upper_n = 2'b11;
        end
    end

    // manual reset keeps registers, only power-on clears them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q.bcf          <= `BCF_RESET;
            s_q.bcs          <= `BCS_RESET;
            s_q.boot_done    <= 1'b0;
            s_q.boot_cnt     <= 2'h0;
            s_q.width_pin_s1 <= 2'b00;
            s_q.width_pin_s2 <= 2'b00;
            s_q.endian_s1    <= 1'b0;
            s_q.endian_s2    <= 1'b0;
            s_q.area0_width  <= `WID_BYTE;
            s_q.back_s1      <= 1'b0;
            s_q.back_s2      <= 1'b0;
            s_q.pu_state     <= PU_IDLE;
            s_q.pu_cnt       <= 3'h0;
            s_q.prdata       <= 32'h0000_0000;
            s_q.dec          <= '{sel_n: 7'h7F, card_upper_n: 2'b11,
                                  width: `WID_BYTE, default: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata             = s_q.prdata;
    assign pready             = 1'b1;
    assign pslverr            = psel && penable && !(hit_bcf || hit_bcs);
    assign dec                = s_q.dec;
    assign little_endian      = s_q.bcf[`BCF_ENDIAN];
    assign addr_pullup        = s_q.pu_state == PU_HOLD;
    assign data_pullup        = s_q.bcf[`BCF_DATA_PU]
                                && &s_q.dec.sel_n;
    assign mem_out_float      = standby && !s_q.bcf[`BCF_FLOAT_MEM];
    assign mem_out_force_high = standby && s_q.bcf[`BCF_FLOAT_MEM];
    assign strobe_out_drive   = s_q.bcf[`BCF_FLOAT_STB];

    a_pullup_len: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(addr_pullup) |-> addr_pullup [*4] ##1 !addr_pullup)
        else $error("address pull-up not exactly four cycles");
    a_area1_nosel: assert property (@(posedge pclk) disable iff (!presetn)
        dec.internal |-> dec.sel_n == 7'h7F)
        else $error("area 1 asserted an external select");
    a_mirror_sel: assert property (@(posedge pclk) disable iff (!presetn)
        acc.valid && acc.addr[28:26] == 3'd4 && manual_reset_n
        |=> !dec.sel_n[4])
        else $error("mirror did not reach area 4");
    a_endian_ro: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.boot_done && $past(s_q.boot_done)
        |-> $stable(little_endian))
        else $error("endian flag changed after boot");
    a_standby_out: assert property (@(posedge pclk) disable iff (!presetn)
        standby |-> mem_out_float != mem_out_force_high)
        else $error("standby output state ambiguous");
    a_dynsize_be: assert property (@(posedge pclk) disable iff (!presetn)
        !little_endian |-> !dec.card_dynsize)
        else $error("card sizing active in big endian");
    a_reserved_sel: assert property (@(posedge pclk) disable iff (!presetn)
        dec.reserved |-> &dec.sel_n)
        else $error("reserved area drove a select");
    a_one_select: assert property (@(posedge pclk) disable iff (!presetn)
        $countones(~dec.sel_n) <= 1)
        else $error("more than one area select");
    c_pullup: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(addr_pullup));
    c_card_io: cover property (@(posedge pclk) disable iff (!presetn)
        dec.card_io);
    c_bcf_wr: cover property (@(posedge pclk) disable iff (!presetn)
        wr_fire && hit_bcf);
endmodule

// ==== rtl/bus_area_params.svh ====
`ifndef BUS_AREA_PARAMS_SVH
`define BUS_AREA_PARAMS_SVH

// register byte addresses on the apb window
`define BCF_ADDR        12'h000
`define BCS_ADDR        12'h004
`define ADDR_LSB        2
`define ADDR_W          12
// first bus control register fields
`define BCF_RESET       16'h0000
`define BCF_ADDR_PU     15
`define BCF_DATA_PU     14
`define BCF_FLOAT_MEM   13
`define BCF_FLOAT_STB   12
`define BCF_ENDIAN      11
`define BCF_A5_CARD     1
`define BCF_A6_CARD     0
`define BCF_WMASK       16'hF7FF
// second bus control register (area 2-6 width)
`define BCS_RESET       16'h3FF0
`define BCS_WMASK       16'h3FF0
// address decode
`define AREA_MSB        28
`define AREA_LSB        26
`define CARD_IO_BIT     25
// widths (two-bit codes)
`define WID_BYTE        2'b01
`define WID_WORD        2'b10
`define WID_LONG        2'b11
// pull-up hold after bus release acknowledge
`define PULLUP_CYCLES   3'h4

`endif

// ==== rtl/bus_area_pkg.sv ====
package bus_area_pkg;
    typedef enum logic [2:0] {
        AREA0, AREA1, AREA2, AREA3, AREA4, AREA5, AREA6, AREA7
    } area_e;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic [3:0]  byte_en;
    } access_s;

    typedef struct packed {
        logic [6:0]  sel_n;
        logic [1:0]  card_upper_n;
        logic        card_io;
        logic        card_dynsize;
        logic        internal;
        logic        reserved;
        logic [1:0]  width;
    } decode_s;

    typedef enum logic [1:0] {PU_IDLE, PU_HOLD, PU_DONE} pullup_e;

    typedef struct packed {
        logic [15:0] bcf;
        logic [15:0] bcs;
        logic        boot_done;
        logic [1:0]  boot_cnt;
        logic [1:0]  width_pin_s1;
        logic [1:0]  width_pin_s2;
        logic        endian_s1;
        logic        endian_s2;
        logic [1:0]  area0_width;
        logic        back_s1;
        logic        back_s2;
        pullup_e     pu_state;
        logic [2:0]  pu_cnt;
        logic [31:0] prdata;
        decode_s     dec;
    } state_s;
endpackage

// ==== testbench/card_model.sv ====
module card_model (
    input  wire logic        pclk,
    input  wire logic [31:0] addr,
    input  wire logic        io16,
    output logic             card_io_16bit_ind
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tog_q = 1'b0;
    // line is not driven outside card io space: toggle, never hold
    always @(posedge pclk) tog_q <= ~tog_q;
    always_comb begin
        card_io_16bit_ind = tog_q;
        if ((addr[28:26] == 3'h5 || addr[28:26] == 3'h6) && addr[25])
            card_io_16bit_ind = io16;
    end
endmodule

// ==== testbench/testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import bus_area_pkg::*;
    logic pclk = 0, presetn = 0, manual_reset_n = 1, psel = 0, penable = 0;
    logic pwrite = 0, standby = 0, bus_release_ack = 0, io16 = 0;
    logic boot_width_pin_lo = 1, boot_width_pin_hi = 0, boot_endian_pin = 0;
    logic pready, pslverr, card_io_16bit_ind, little_endian, addr_pullup;
    logic data_pullup, mem_out_force_high, mem_out_float, strobe_out_drive;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    access_s     acc = '0;
    decode_s     dec;
    logic [15:0] bcf, bcs, lfsr = 16'h5091;
    logic [15:0] bw [1:3] = '{16'h1550, 16'h2AA0, 16'h2BF0};
    logic [15:0] dq [$];
    logic [32:0] rq [$];
    logic [15:0] de;
    logic [31:0] rd_q;
    logic        v_d = 0, r_d = 0, e_d = 0;
    int failures = 0, n_checks = 0, cyc = 0;
    always #5 pclk = ~pclk;
    bus_area_decode u_dut (.pclk, .presetn, .manual_reset_n, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr,
        .acc, .card_io_16bit_ind, .boot_width_pin_lo, .boot_width_pin_hi,
        .boot_endian_pin, .standby, .bus_release_ack, .dec, .little_endian,
        .addr_pullup, .data_pullup, .mem_out_force_high, .mem_out_float,
        .strobe_out_drive);
    card_model u_card (.pclk, .addr(acc.addr), .io16, .card_io_16bit_ind);
    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            results();
        end
    end
    always @(posedge pclk) begin
        v_d <= acc.valid;
        r_d <= psel && penable && pready && !pwrite;
        e_d <= pslverr;
        rd_q <= prdata;
    end
    always @(negedge pclk) begin
        if (v_d) begin
            de = dq.pop_front();
            check({dec.card_upper_n, dec.sel_n, dec.card_io,
                dec.card_dynsize, dec.internal, dec.reserved,
                de[15] ? dec.width : 2'b00}, de[14:0]);
        end
        if (r_d)
            check({e_d, e_d ? 32'h0000_0000 : rd_q}, rq.pop_front());
    end
    function automatic logic [15:0] dexp(input logic [31:0] a, input logic s);
        logic [2:0] ar;
        logic       ci;
        logic       cp;
        ar = a[28:26];
        cp = ar == 3'h5 ? bcf[1] : ar == 3'h6 & bcf[0];
        ci = a[25] & cp;
        return {ar != 3'h1, cp ? (ar == 3'h6 ? 2'b01 : 2'b10) : 2'b11,
            ~(7'h1 << ar) | 7'h2, ci, ci & bcf[11] & s,
            ar == 3'h1, 1'b0, ar == 3'h0 ?
            {boot_width_pin_hi, boot_width_pin_lo} : bcs[2 * ar + 1 -: 2]};
    endfunction
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [15:0] d, input logic [32:0] exp);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        if (!wr)
            rq.push_back(exp);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic burst;
        logic [31:0] a;
        repeat (16) begin
            lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
            a = {lfsr[2:0], lfsr[5:3], lfsr[15:0], lfsr[15:6]};
            if (a[28:26] == 3'h7)
                a[26] = 1'b0;
            io16 <= lfsr[9];
            acc <= '{1'b1, a, 4'hF};
            dq.push_back(dexp(a, lfsr[9]));
            @(posedge pclk);
        end
        acc.valid <= 1'b0;
        @(posedge pclk);
    endtask
    initial begin
        logic k;
        int   n;
        for (int i = 1; i < 4; i++) begin
            k = i[0];
            {boot_width_pin_hi, boot_width_pin_lo} <= i[1:0];
            boot_endian_pin <= k;
            presetn <= 1'b0;
            repeat (5) @(posedge pclk);
            presetn <= 1'b1;
            repeat (4) @(posedge pclk);
            bcf = {4'h0, k, 11'h000};
            bcs = 16'h3FF0;
            apb(0, 12'h000, 16'h0000, {17'h0_0000, bcf});
            apb(0, 12'h004, 16'h0000, {17'h0_0000, bcs});
            apb(0, 12'h008, 16'h0000, {1'b1, 32'h0000_0000});
            apb(1, 12'h000, k ? 16'hF003 : 16'h0800, 33'h0_0000_0000);
            bcf = ((k ? 16'hF003 : 16'h0800) & 16'hF7FF) | (bcf & 16'h0800);
            apb(1, 12'h004, bw[i], 33'h0_0000_0000);
            bcs = bw[i] & 16'h3FF0;
            apb(0, 12'h000, 16'h0000, {17'h0_0000, bcf});
            apb(0, 12'h004, 16'h0000, {17'h0_0000, bcs});
            burst();
            standby <= 1'b1;
            @(negedge pclk);
            check({mem_out_float, mem_out_force_high, data_pullup,
                strobe_out_drive, little_endian}, {~k, k, k, k, k});
            @(posedge pclk);
            standby <= 1'b0;
            bus_release_ack <= 1'b1;
            n = 0;
            repeat (12) begin
                @(negedge pclk);
                n += int'(addr_pullup);
            end
            check(33'(n), 33'(4 * k));
            @(posedge pclk);
            bus_release_ack <= 1'b0;
            manual_reset_n <= 1'b0;
            repeat (3) @(posedge pclk);
            manual_reset_n <= 1'b1;
            @(posedge pclk);
            apb(0, 12'h000, 16'h0000, {17'h0_0000, bcf});
        end
        results();
    end
endmodule
